// ---- inc/repeater_status_pkg.sv ----
// Operation
// - The port-fault indicator bus low four bits step through ports 0 to 11 and repeat.
// - Bit four of the indicator bus is high while the shown port is partitioned.
// - Bit five of the indicator bus is high while the shown port is jabbering.
// - The chip id error output follows the id error status condition, registered one clock later.
// - During reset the shared state bit three pin is an input whose level sets receive polarity.
// - A high or open polarity pin during reset makes the receive enables active high.
// - A low polarity pin during reset makes the receive enables active low.
// - Outside reset the shared pin drives state code bit three beside the three lower bits.
// - State codes are 0 idle, 1 collision, 2 one port left, 3 repeat, 4 noise.
// - Mode inputs 0,0 select no special mode and 1,1 select preamble regeneration.
// - A receive enable is asserted only for the single port with receive activity.
package repeater_status_pkg;
    localparam int NUM_PORTS = 12;
    localparam int PORT_IDX_W = 4;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCAN_DWELL_NS = 1000;
    localparam int SCAN_DWELL_CYCLES = (SCAN_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************
    // register map
    // ************************************
    localparam logic [7:0] STATUS_OFFSET = 8'h00;
    localparam logic [7:0] MASK_OFFSET = 8'h04;
    localparam logic [7:0] STATE_OFFSET = 8'h08;
    localparam logic [7:0] FAULT_OFFSET = 8'h0c;
    localparam int STATUS_W = 4;
    localparam int ST_ID_ERR = 0;
    localparam int ST_PART = 1;
    localparam int ST_JAB = 2;
    localparam int ST_MODE = 3;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam int STATE_CODE_LSB = 0;
    localparam int STATE_POL_BIT = 4;
    localparam int STATE_MODE_LSB = 8;
    localparam int STATE_SCAN_LSB = 12;
    localparam int FAULT_PART_LSB = 0;
    localparam int FAULT_JAB_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************
    // state codes and modes
    // ************************************
    localparam logic [3:0] RSM_IDLE = 4'h0;
    localparam logic [3:0] RSM_COLLISION = 4'h1;
    localparam logic [3:0] RSM_ONE_LEFT = 4'h2;
    localparam logic [3:0] RSM_REPEAT = 4'h3;
    localparam logic [3:0] RSM_NOISE = 4'h4;
    localparam logic [1:0] MODE_PLAIN_CODE = 2'h0;
    localparam logic [1:0] MODE_REGEN_CODE = 2'h3;
    typedef enum logic [1:0] {MODE_NONE, MODE_TEST, MODE_PREAMBLE_REGEN} mode_t;
endpackage

// ---- src/led_port_scanner.sv ----
`timescale 1ns/1ns
module led_port_scanner #(
    parameter int NUM_PORTS = repeater_status_pkg::NUM_PORTS,
    parameter int DWELL_CYCLES = repeater_status_pkg::SCAN_DWELL_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_PORTS-1:0] port_partitioned,
    input wire logic [NUM_PORTS-1:0] port_jabbering,
    output logic [5:0] port_fault_indicator_bus
);
    localparam int DWELL_MAX = DWELL_CYCLES - 1;
    logic [15:0] dwell_cnt;
    logic [3:0] port_idx;
    logic [NUM_PORTS-1:0] part_q;
    logic [NUM_PORTS-1:0] jab_q;
    wire step = (dwell_cnt == 16'(DWELL_MAX));
    wire last_port = (port_idx == 4'(NUM_PORTS - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dwell_cnt <= 16'h0000;
            port_idx <= 4'h0;
        end else begin
            dwell_cnt <= step ? 16'h0000 : dwell_cnt + 16'h0001;
            if (step)
                port_idx <= last_port ? 4'h0 : port_idx + 4'h1;
        end
    end

    // number and status leave the same flop stage, so they never disagree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_fault_indicator_bus <= 6'h00;
        end else begin
            port_fault_indicator_bus <= {port_jabbering[port_idx], port_partitioned[port_idx],
                                         port_idx};
        end
        part_q <= port_partitioned;
        jab_q <= port_jabbering;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_SCAN_WRAP: assert property (step && last_port |=> port_idx == 4'h0)
        else $error("scan did not wrap to port 0");
    AST_PART_BIT: assert property ($past(aresetn)
        |-> port_fault_indicator_bus[4] == part_q[port_fault_indicator_bus[3:0]])
        else $error("partition bit does not match shown port");
    AST_JAB_BIT: assert property ($past(aresetn)
        |-> port_fault_indicator_bus[5] == jab_q[port_fault_indicator_bus[3:0]])
        else $error("jabber bit does not match shown port");
    AST_DWELL: assert property (port_idx != $past(port_idx)
        |-> $past(dwell_cnt) == 16'(DWELL_MAX))
        else $error("port number changed before dwell elapsed");
    AST_RANGE: assert property (port_fault_indicator_bus[3:0] < 4'(NUM_PORTS))
        else $error("port number out of range");
endmodule

// ---- src/polarity_strap.sv ----
`timescale 1ns/1ns
module polarity_strap (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic state_bit3_in,
    input wire logic state_bit3_drive,
    output logic state_bit3_out,
    output logic state_bit3_oe_n,
    output logic polarity_high
);
    // reset is synchronous, so the strap is sampled on every edge while held
    always_ff @(posedge aclk) begin
        if (!aresetn)
            polarity_high <= state_bit3_in;
    end

    // pin released while in reset so the pull resistor sets its level
    assign state_bit3_oe_n = !aresetn;
    assign state_bit3_out = state_bit3_drive;

    AST_STRAP: assert property (@(posedge aclk)
        !aresetn |=> polarity_high == $past(state_bit3_in))
        else $error("polarity not taken from pin during reset");
    AST_HOLD: assert property (@(posedge aclk)
        $past(aresetn) && aresetn |-> $stable(polarity_high))
        else $error("polarity changed outside reset");
    AST_PIN_DRV: assert property (@(posedge aclk)
        aresetn |-> !state_bit3_oe_n && state_bit3_out == state_bit3_drive)
        else $error("shared pin not driven outside reset");
endmodule

// ---- src/repeater_status_pins.sv ----
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module repeater_status_pins #(
    parameter int NUM_PORTS = repeater_status_pkg::NUM_PORTS,
    parameter int DWELL_CYCLES = repeater_status_pkg::SCAN_DWELL_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    // observed repeater state
    input wire logic [NUM_PORTS-1:0] port_partitioned,
    input wire logic [NUM_PORTS-1:0] port_jabbering,
    input wire logic [NUM_PORTS-1:0] port_rx_active,
    input wire logic [3:0] repeater_state_in,
    input wire logic id_error_cond,
    input wire logic [1:0] mode_in,
    // pins
    output logic [5:0] port_fault_indicator_bus,
    output logic chip_id_error_out,
    output logic [2:0] repeater_state_code,
    input wire logic state_bit3_in,
    output logic state_bit3_out,
    output logic state_bit3_oe_n,
    output logic [NUM_PORTS-1:0] port_receive_enable,
    output logic mode_test,
    output logic mode_preamble_regen
);
    // ************************************
    // declarations
    // ************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [3:0] status;
    logic [3:0] mask;
    logic [3:0] next_status;
    logic [NUM_PORTS-1:0] part_q;
    logic [NUM_PORTS-1:0] jab_q;
    logic [NUM_PORTS-1:0] rx_en_q;
    logic [NUM_PORTS-1:0] rx_active_q;
    logic code3_q;
    logic polarity_high;
    repeater_status_pkg::mode_t mode_sel;
    repeater_status_pkg::mode_t mode_q;
    logic [31:0] rd_mux;
    logic [1:0] rd_resp;

    // ************************************
    // axi4-lite write path
    // ************************************
    // address and data may arrive in either order; each is parked until both exist
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_held || aw_fire;
    wire have_w = w_held || w_fire;
    wire do_write = have_aw && have_w && !s_axi_bvalid;
    wire [7:0] wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held ? w_strb_q : s_axi_wstrb;
    wire wr_status = do_write && wr_addr == repeater_status_pkg::STATUS_OFFSET;
    wire wr_mask = do_write && wr_addr == repeater_status_pkg::MASK_OFFSET;
    wire wr_known = wr_status || wr_mask;
    wire [3:0] status_clr = (wr_status && wr_strb[0]) ? wr_data[3:0] : 4'h0;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            aw_held <= do_write ? 1'b0 : have_aw;
            w_held <= do_write ? 1'b0 : have_w;
            if (aw_fire)
                aw_addr_q <= s_axi_awaddr;
            if (w_fire) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= repeater_status_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? repeater_status_pkg::RESP_OKAY
                                    : repeater_status_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************
    // axi4-lite read path
    // ************************************
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire rd_status = s_axi_araddr == repeater_status_pkg::STATUS_OFFSET;
    wire rd_mask = s_axi_araddr == repeater_status_pkg::MASK_OFFSET;
    wire rd_state = s_axi_araddr == repeater_status_pkg::STATE_OFFSET;
    wire rd_fault = s_axi_araddr == repeater_status_pkg::FAULT_OFFSET;
    wire [31:0] state_word = (32'(repeater_state_in) << repeater_status_pkg::STATE_CODE_LSB)
        | (32'(polarity_high) << repeater_status_pkg::STATE_POL_BIT)
        | (32'(mode_q) << repeater_status_pkg::STATE_MODE_LSB)
        | (32'(port_fault_indicator_bus[3:0]) << repeater_status_pkg::STATE_SCAN_LSB);
    wire [31:0] fault_word = (32'(part_q) << repeater_status_pkg::FAULT_PART_LSB)
        | (32'(jab_q) << repeater_status_pkg::FAULT_JAB_LSB);

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_mux = rd_status ? 32'(status)
                  : rd_mask ? 32'(mask)
                  : rd_state ? state_word
                  : rd_fault ? fault_word
                  : 32'h0000_0000;
    assign rd_resp = (rd_status || rd_mask || rd_state || rd_fault)
                   ? repeater_status_pkg::RESP_OKAY : repeater_status_pkg::RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= repeater_status_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_resp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************
    // events, status and interrupt
    // ************************************
    wire [3:0] events;
    assign events[repeater_status_pkg::ST_ID_ERR] = id_error_cond;
    assign events[repeater_status_pkg::ST_PART] = |(port_partitioned & ~part_q);
    assign events[repeater_status_pkg::ST_JAB] = |(port_jabbering & ~jab_q);
    assign events[repeater_status_pkg::ST_MODE] = mode_sel != mode_q;
    // a new event beats a clear written in the same cycle
    assign next_status = (status & ~status_clr) | events;
    assign irq = |(status & mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= repeater_status_pkg::STATUS_RESET;
            mask <= repeater_status_pkg::MASK_RESET;
            part_q <= '0;
            jab_q <= '0;
        end else begin
            status <= next_status;
            if (wr_mask && wr_strb[0])
                mask <= wr_data[3:0];
            part_q <= port_partitioned;
            jab_q <= port_jabbering;
        end
    end

    // ************************************
    // id error and state code outputs
    // ************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chip_id_error_out <= 1'b0;
            repeater_state_code <= repeater_status_pkg::RSM_IDLE[2:0];
            code3_q <= repeater_status_pkg::RSM_IDLE[3];
        end else begin
            chip_id_error_out <= id_error_cond;
            repeater_state_code <= repeater_state_in[2:0];
            code3_q <= repeater_state_in[3];
        end
    end

    // ************************************
    // receive enables
    // ************************************
    // a collision (several active ports) enables none of them
    wire rx_single = (port_rx_active != '0)
        && ((port_rx_active & (port_rx_active - NUM_PORTS'(1))) == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_en_q <= '0;
            rx_active_q <= '0;
        end else begin
            rx_en_q <= rx_single ? port_rx_active : '0;
            rx_active_q <= port_rx_active;
        end
    end

    assign port_receive_enable = rx_en_q ^ {NUM_PORTS{!polarity_high}};

    // ************************************
    // mode decode
    // ************************************
    // both test codes are treated alike; the board only applies them on a tester
    assign mode_sel = (mode_in == repeater_status_pkg::MODE_PLAIN_CODE)
                    ? repeater_status_pkg::MODE_NONE
                    : (mode_in == repeater_status_pkg::MODE_REGEN_CODE)
                    ? repeater_status_pkg::MODE_PREAMBLE_REGEN
                    : repeater_status_pkg::MODE_TEST;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            mode_q <= repeater_status_pkg::MODE_NONE;
        else
            mode_q <= mode_sel;
    end

    always_comb begin
        mode_test = 1'b0;
        mode_preamble_regen = 1'b0;
        case (mode_q)
            repeater_status_pkg::MODE_NONE: begin
                mode_test = 1'b0;
            end
            repeater_status_pkg::MODE_TEST: begin
                mode_test = 1'b1;
            end
            repeater_status_pkg::MODE_PREAMBLE_REGEN: begin
                mode_preamble_regen = 1'b1;
            end
            default: begin
                mode_test = 1'b0;
            end
        endcase
    end

    // ************************************
    // submodules
    // ************************************
    led_port_scanner #(
        .NUM_PORTS(NUM_PORTS),
        .DWELL_CYCLES(DWELL_CYCLES)
    ) scanner (
        .aclk(aclk),
        .aresetn(aresetn),
        .port_partitioned(port_partitioned),
        .port_jabbering(port_jabbering),
        .port_fault_indicator_bus(port_fault_indicator_bus)
    );

    polarity_strap strap (
        .aclk(aclk),
        .aresetn(aresetn),
        .state_bit3_in(state_bit3_in),
        .state_bit3_drive(code3_q),
        .state_bit3_out(state_bit3_out),
        .state_bit3_oe_n(state_bit3_oe_n),
        .polarity_high(polarity_high)
    );

    // ************************************
    // checks
    // ************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_ID_ERR: assert property (id_error_cond
        |=> chip_id_error_out && status[repeater_status_pkg::ST_ID_ERR])
        else $error("id error output or status not raised");
    AST_ID_ERR_LOW: assert property (!id_error_cond |=> !chip_id_error_out)
        else $error("id error output high without cause");
    AST_RXE_COLL: assert property ($past(aresetn) && !$onehot(rx_active_q)
        |-> port_receive_enable == {NUM_PORTS{!polarity_high}})
        else $error("receive enable asserted without single active port");
    AST_RXE_ONE: assert property ($past(aresetn) && $onehot(rx_active_q)
        |-> port_receive_enable == (rx_active_q ^ {NUM_PORTS{!polarity_high}}))
        else $error("receive enable not on the single active port");
    AST_CODE: assert property (##1 $past(aresetn)
        |-> {state_bit3_out, repeater_state_code} == $past(repeater_state_in))
        else $error("state code not forwarded");
    AST_MODE_REGEN: assert property (mode_in == 2'h3 |=> mode_preamble_regen && !mode_test)
        else $error("preamble regeneration not selected");
    AST_MODE_NONE: assert property (mode_in == 2'h0 |=> !mode_preamble_regen && !mode_test)
        else $error("special mode selected on 0,0");
    AST_STICKY: assert property (status[1] && !(wr_status && wr_strb[0] && wr_data[1])
        |=> status[1])
        else $error("status bit lost without clear");
endmodule

// ---- bench/board_model.sv ----
`timescale 1ns/1ns
// ************************************
// board straps and lamp decoder
// ************************************
module board_model (
    input wire logic aclk,
    input wire logic [1:0] strap_sel,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic pin_level,
    input wire logic [5:0] led_bus,
    output logic [11:0] led_part,
    output logic [11:0] led_jab
);
    // 0 open, 1 pull-up, 2 pull-down; open floats high, so only 2 gives low
    assign pin_level = pin_oe_n ? (strap_sel != 2'h2) : pin_out;
    // codes 12..15 light nothing, so a bad count leaves stale lamps
    always_ff @(posedge aclk) begin
        if (led_bus[3:0] < 4'hc) begin
            led_part[led_bus[3:0]] <= led_bus[4];
            led_jab[led_bus[3:0]] <= led_bus[5];
        end
    end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    localparam int DW = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, irq, id_out, b3_out, b3_oe_n, b3_pin;
    logic m_test, m_regen;
    logic [1:0] bresp, rresp, r, mode = 2'h0, strap = 2'h0;
    logic [11:0] part = 12'h0, jab = 12'h0, rx = 12'h0, rxe, led_part, led_jab;
    logic [3:0] st_in = 4'h0, prev;
    logic id_cond = 1'b0;
    logic [5:0] bus;
    logic [2:0] code;
    int bad_count = 0;
    int n_tests = 0;
    int run, first;
    always #10 aclk = ~aclk;
    repeater_status_pins #(.DWELL_CYCLES(DW)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq(irq), .port_partitioned(part), .port_jabbering(jab), .port_rx_active(rx),
        .repeater_state_in(st_in), .id_error_cond(id_cond), .mode_in(mode),
        .port_fault_indicator_bus(bus), .chip_id_error_out(id_out), .repeater_state_code(code),
        .state_bit3_in(b3_pin), .state_bit3_out(b3_out), .state_bit3_oe_n(b3_oe_n),
        .port_receive_enable(rxe), .mode_test(m_test), .mode_preamble_regen(m_regen));
    board_model partner (.aclk(aclk), .strap_sel(strap), .pin_out(b3_out),
        .pin_oe_n(b3_oe_n), .pin_level(b3_pin), .led_bus(bus), .led_part(led_part),
        .led_jab(led_jab));
    // ************************************
    // bus tasks
    // ************************************
    // readies are looked at on the falling edge, where they equal what the next rising edge sees
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ah, wh, bh;
        bh = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bh) begin
            @(negedge aclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid & bready;
            rs = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ah, rh;
        rh = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rh) begin
            @(negedge aclk);
            ah = arvalid & arready;
            rh = rvalid & rready;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
        end
    endtask
    task automatic settle;
        repeat (2) @(negedge aclk);
    endtask
    task automatic do_reset(input logic [11:0] idle);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (15) @(posedge aclk);
        @(negedge aclk);
        `CHK(b3_oe_n, 1'b1)
        `CHK(rxe, idle)
        @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic rxe_test(input logic [11:0] idle);
        logic [11:0] rx_tab [4];
        logic [11:0] ex_tab [4];
        rx_tab = '{12'h001, 12'h800, 12'h011, 12'h000};
        ex_tab = '{12'h001, 12'h800, 12'h000, 12'h000};
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            rx <= rx_tab[i];
            settle();
            `CHK(rxe, ex_tab[i] ^ idle)
        end
        $display("receive enable test done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(40000 * 20);
        bad_count++;
        close_out();
    end
    // ************************************
    // tests
    // ************************************
    initial begin
        do_reset(12'h000);
        axi_rd(8'h04, d, r);
        `CHK(d, 32'h0)
        axi_rd(8'h08, d, r);
        `CHK(d[4], 1'b1)
        rxe_test(12'h000);
        for (int i = 0; i < 6; i++) begin
            @(posedge aclk);
            st_in <= (i == 5) ? 4'h8 : 4'(i);
            settle();
            `CHK({b3_pin, code}, st_in)
            `CHK(b3_oe_n, 1'b0)
        end
        $display("state code test done");
        for (int m = 0; m < 4; m++) begin
            @(posedge aclk);
            mode <= 2'(m);
            settle();
            `CHK({m_test, m_regen}, (m == 0) ? 2'h0 : (m == 3) ? 2'h1 : 2'h2)
        end
        @(posedge aclk);
        mode <= 2'h0;
        $display("mode test done");
        @(posedge aclk);
        id_cond <= 1'b1;
        settle();
        `CHK(id_out, 1'b1)
        `CHK(irq, 1'b0)
        @(posedge aclk);
        id_cond <= 1'b0;
        settle();
        `CHK(id_out, 1'b0)
        axi_wr(8'h04, 32'h1, r);
        `CHK(irq, 1'b1)
        axi_rd(8'h00, d, r);
        `CHK(d[0], 1'b1)
        axi_wr(8'h00, 32'h1, r);
        `CHK(irq, 1'b0)
        axi_wr(8'h08, 32'h1, r);
        `CHK(r, 2'h2)
        axi_rd(8'h40, d, r);
        `CHK({r, d}, {2'h2, 32'h0})
        $display("register test done");
        @(posedge aclk);
        part <= 12'h008;
        jab <= 12'h020;
        settle();
        prev = bus[3:0];
        run = 0;
        first = 1;
        repeat (120) begin
            @(negedge aclk);
            `CHK(bus[4], part[bus[3:0]])
            `CHK(bus[5], jab[bus[3:0]])
            if (bus[3:0] !== prev) begin
                `CHK(bus[3:0], (prev == 4'hb) ? 4'h0 : prev + 4'h1)
                if (!first) `CHK(run, DW)
                first = 0;
                prev = bus[3:0];
                run = 1;
            end else
                run++;
        end
        `CHK({led_part, led_jab}, {part, jab})
        $display("scan test done");
        @(posedge aclk);
        strap <= 2'h2;
        do_reset(12'hfff);
        // non-blocking, so the strap sampled at the release edge is still the pull-down
        strap <= 2'h1;
        rxe_test(12'hfff);
        do_reset(12'h000);
        axi_rd(8'h08, d, r);
        `CHK(d[4], 1'b1)
        $display("pull-up strap test done");
        close_out();
    end
endmodule
